// *** aod_pkg.sv ***
`default_nettype none

package aod_pkg;

    localparam int unsigned CLK_PERIOD_NS = 10;

    // Opcode bases and masks
    localparam logic [7:0] OPC_ADC_IND   = 8'h36;
    localparam logic [7:0] OPC_ADC_IMM   = 8'h34;
    localparam logic [7:0] OPC_SBB_REG   = 8'h98;
    localparam logic [7:0] OPC_SBB_DIR   = 8'h95;
    localparam logic [7:0] OPC_SBB_IND   = 8'h96;
    localparam logic [7:0] OPC_SBB_IMM   = 8'h94;
    localparam logic [7:0] OPC_INC_ACC   = 8'h04;
    localparam logic [7:0] OPC_INC_REG   = 8'h08;
    localparam logic [7:0] OPC_INC_DIR   = 8'h05;
    localparam logic [7:0] OPC_INC_IND   = 8'h06;
    localparam logic [7:0] OPC_DEC_ACC   = 8'h14;
    localparam logic [7:0] OPC_DEC_REG   = 8'h18;
    localparam logic [7:0] OPC_DEC_DIR   = 8'h15;
    localparam logic [7:0] OPC_DEC_IND   = 8'h16;
    localparam logic [7:0] OPC_INC_DPP   = 8'hA3;
    localparam logic [7:0] OPC_AND_REG   = 8'h58;
    localparam logic [7:0] MASK_REG_GRP  = 8'hF8;
    localparam logic [7:0] MASK_IND_GRP  = 8'hFE;

    // Lengths in bytes and machine cycles
    localparam logic [1:0] LEN_ONE       = 2'h1;
    localparam logic [1:0] LEN_TWO       = 2'h2;
    localparam logic [1:0] CYC_ONE       = 2'h1;
    localparam logic [1:0] CYC_TWO       = 2'h2;
    localparam logic [1:0] CYC_THREE     = 2'h3;

    typedef enum logic [2:0] {
        AOD_OP_NONE = 3'b000,
        AOD_OP_ADC  = 3'b001,
        AOD_OP_SBB  = 3'b010,
        AOD_OP_INC  = 3'b011,
        AOD_OP_DEC  = 3'b100,
        AOD_OP_AND  = 3'b101
    } aod_op_t;

    typedef enum logic [2:0] {
        AOD_SRC_NONE = 3'b000,
        AOD_SRC_ACC  = 3'b001,
        AOD_SRC_REG  = 3'b010,
        AOD_SRC_DIR  = 3'b011,
        AOD_SRC_IND  = 3'b100,
        AOD_SRC_IMM  = 3'b101,
        AOD_SRC_DPP  = 3'b110
    } aod_src_t;

    typedef struct packed {
        logic       valid;
        aod_op_t    op;
        aod_src_t   src;
        logic [2:0] bank_sel;
        logic       ptr_sel;
        logic       use_carry;
        logic       carry_upd;
        logic [1:0] bytes;
        logic [1:0] cycles;
    } aod_dec_t;

    localparam aod_dec_t DEC_RESET = '{
        valid: 1'b0, op: AOD_OP_NONE, src: AOD_SRC_NONE, bank_sel: 3'h0,
        ptr_sel: 1'b0, use_carry: 1'b0, carry_upd: 1'b0,
        bytes: 2'h0, cycles: 2'h0};

endpackage : aod_pkg

`default_nettype wire

// *** aod_arith_opcode_decode.sv ***
// Summary of operation
// - 36h/37h: add indirect byte plus carry, one byte, one cycle
// - 34h: add immediate plus carry, two bytes, two cycles
// - 98h-9Fh: subtract bank register with borrow, one byte, one cycle
// - 95h: subtract direct byte with borrow, two bytes, two cycles
// - 96h/97h: subtract indirect byte with borrow, one byte, one cycle
// - 94h: subtract immediate with borrow, two bytes, two cycles
// - 04h: increment accumulator, one byte, one cycle
// - 08h-0Fh: increment bank register, one byte, one cycle
// - 05h: increment direct byte, two bytes, two cycles
// - 06h/07h: increment indirect byte, one byte, one cycle
// - 14h: decrement accumulator, one byte, one cycle
// - 18h-1Fh: decrement bank register, one byte, one cycle
// - 15h: decrement direct byte, two bytes, two cycles
// - 16h/17h: decrement indirect byte, one byte, one cycle
// - A3h: increment data pointer pair, one byte, three cycles
// - 58h-5Fh: AND bank register into accumulator, one byte, one cycle
`timescale 1ns/10ps
`default_nettype none

module aod_arith_opcode_decode (
    input  wire logic              i_clk,
    input  wire logic              i_reset,
    input  wire logic              i_op_valid,
    input  wire logic [7:0]        i_opcode,
    output var  aod_pkg::aod_dec_t o_dec
);
    import aod_pkg::*;

    aod_dec_t dec_d;
    aod_dec_t dec_q;

    function automatic logic in_grp(input logic [7:0] opc,
                                    input logic [7:0] base,
                                    input logic [7:0] mask);
        in_grp = ((opc & mask) == base);
    endfunction : in_grp

    always_comb begin
        dec_d          = DEC_RESET;
        dec_d.bank_sel = i_opcode[2:0];
        dec_d.ptr_sel  = i_opcode[0];
        dec_d.bytes    = LEN_ONE;
        dec_d.cycles   = CYC_ONE;
        if (in_grp(i_opcode, OPC_ADC_IND, MASK_IND_GRP)) begin
            dec_d.op  = AOD_OP_ADC;
            dec_d.src = AOD_SRC_IND;
        end else if (i_opcode == OPC_ADC_IMM) begin
            dec_d.op     = AOD_OP_ADC;
            dec_d.src    = AOD_SRC_IMM;
            dec_d.bytes  = LEN_TWO;
            dec_d.cycles = CYC_TWO;
        end else if (in_grp(i_opcode, OPC_SBB_REG, MASK_REG_GRP)) begin
            dec_d.op  = AOD_OP_SBB;
            dec_d.src = AOD_SRC_REG;
        end else if (i_opcode == OPC_SBB_DIR) begin
            dec_d.op     = AOD_OP_SBB;
            dec_d.src    = AOD_SRC_DIR;
            dec_d.bytes  = LEN_TWO;
            dec_d.cycles = CYC_TWO;
        end else if (in_grp(i_opcode, OPC_SBB_IND, MASK_IND_GRP)) begin
            dec_d.op  = AOD_OP_SBB;
            dec_d.src = AOD_SRC_IND;
        end else if (i_opcode == OPC_SBB_IMM) begin
            dec_d.op     = AOD_OP_SBB;
            dec_d.src    = AOD_SRC_IMM;
            dec_d.bytes  = LEN_TWO;
            dec_d.cycles = CYC_TWO;
        end else if (i_opcode == OPC_INC_ACC) begin
            dec_d.op  = AOD_OP_INC;
            dec_d.src = AOD_SRC_ACC;
        end else if (in_grp(i_opcode, OPC_INC_REG, MASK_REG_GRP)) begin
            dec_d.op  = AOD_OP_INC;
            dec_d.src = AOD_SRC_REG;
        end else if (i_opcode == OPC_INC_DIR) begin
            dec_d.op     = AOD_OP_INC;
            dec_d.src    = AOD_SRC_DIR;
            dec_d.bytes  = LEN_TWO;
            dec_d.cycles = CYC_TWO;
        end else if (in_grp(i_opcode, OPC_INC_IND, MASK_IND_GRP)) begin
            dec_d.op  = AOD_OP_INC;
            dec_d.src = AOD_SRC_IND;
        end else if (i_opcode == OPC_DEC_ACC) begin
            dec_d.op  = AOD_OP_DEC;
            dec_d.src = AOD_SRC_ACC;
        end else if (in_grp(i_opcode, OPC_DEC_REG, MASK_REG_GRP)) begin
            dec_d.op  = AOD_OP_DEC;
            dec_d.src = AOD_SRC_REG;
        end else if (i_opcode == OPC_DEC_DIR) begin
            dec_d.op     = AOD_OP_DEC;
            dec_d.src    = AOD_SRC_DIR;
            dec_d.bytes  = LEN_TWO;
            dec_d.cycles = CYC_TWO;
        end else if (in_grp(i_opcode, OPC_DEC_IND, MASK_IND_GRP)) begin
            dec_d.op  = AOD_OP_DEC;
            dec_d.src = AOD_SRC_IND;
        end else if (i_opcode == OPC_INC_DPP) begin
            // Sixteen-bit carry chain needs the extra cycles
            dec_d.op     = AOD_OP_INC;
            dec_d.src    = AOD_SRC_DPP;
            dec_d.cycles = CYC_THREE;
        end else if (in_grp(i_opcode, OPC_AND_REG, MASK_REG_GRP)) begin
            dec_d.op  = AOD_OP_AND;
            dec_d.src = AOD_SRC_REG;
        end else begin
            // Other groups belong to other decoders
            dec_d.bytes  = 2'h0;
            dec_d.cycles = 2'h0;
        end
        dec_d.use_carry = (dec_d.op == AOD_OP_ADC) ||
                          (dec_d.op == AOD_OP_SBB);
        dec_d.carry_upd = dec_d.use_carry;
        dec_d.valid     = i_op_valid && (dec_d.op != AOD_OP_NONE);
        if (!dec_d.valid) begin
            dec_d = DEC_RESET;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            dec_q <= DEC_RESET;
        end else begin
            dec_q <= dec_d;
        end
    end

    assign o_dec = dec_q;

    logic [7:0] opc_q;
    logic       in_q;
    always_ff @(posedge i_clk) begin
        opc_q <= i_opcode;
        in_q  <= i_op_valid;
    end

    property p_adc_ind;
        @(posedge i_clk) disable iff (i_reset)
        i_op_valid && (i_opcode[7:1] == 7'h1B) |=> o_dec.valid &&
            o_dec.op == AOD_OP_ADC && o_dec.src == AOD_SRC_IND &&
            o_dec.bytes == 2'h1 && o_dec.cycles == 2'h1;
    endproperty
    a_adc_ind: assert property (p_adc_ind)
        else $error("indirect add with carry misdecoded");

    property p_two_byte;
        @(posedge i_clk) disable iff (i_reset)
        i_op_valid && (i_opcode == 8'h34 || i_opcode == 8'h95 ||
            i_opcode == 8'h94 || i_opcode == 8'h05 || i_opcode == 8'h15)
        |=> o_dec.bytes == 2'h2 && o_dec.cycles == 2'h2;
    endproperty
    a_two_byte: assert property (p_two_byte)
        else $error("two byte form has wrong length");

    property p_sbb_reg;
        @(posedge i_clk) disable iff (i_reset)
        i_op_valid && i_opcode[7:3] == 5'h13 |=> o_dec.op == AOD_OP_SBB &&
            o_dec.src == AOD_SRC_REG && o_dec.bytes == 2'h1;
    endproperty
    a_sbb_reg: assert property (p_sbb_reg)
        else $error("register subtract misdecoded");

    property p_sbb_ind;
        @(posedge i_clk) disable iff (i_reset)
        i_op_valid && i_opcode[7:1] == 7'h4B |=> o_dec.op == AOD_OP_SBB &&
            o_dec.src == AOD_SRC_IND && o_dec.cycles == 2'h1;
    endproperty
    a_sbb_ind: assert property (p_sbb_ind)
        else $error("indirect subtract misdecoded");

    property p_inc_reg;
        @(posedge i_clk) disable iff (i_reset)
        i_op_valid && i_opcode[7:3] == 5'h01 |=> o_dec.op == AOD_OP_INC &&
            o_dec.src == AOD_SRC_REG;
    endproperty
    a_inc_reg: assert property (p_inc_reg)
        else $error("register increment misdecoded");

    property p_dec_ind;
        @(posedge i_clk) disable iff (i_reset)
        i_op_valid && i_opcode[7:1] == 7'h0B |=> o_dec.op == AOD_OP_DEC &&
            o_dec.src == AOD_SRC_IND;
    endproperty
    a_dec_ind: assert property (p_dec_ind)
        else $error("indirect decrement misdecoded");

    property p_dpp;
        @(posedge i_clk) disable iff (i_reset)
        i_op_valid && i_opcode == 8'hA3 |=> o_dec.src == AOD_SRC_DPP &&
            o_dec.bytes == 2'h1 && o_dec.cycles == 2'h3;
    endproperty
    a_dpp: assert property (p_dpp)
        else $error("pointer increment timing wrong");

    property p_and_reg;
        @(posedge i_clk) disable iff (i_reset)
        i_op_valid && i_opcode[7:3] == 5'h0B |=> o_dec.op == AOD_OP_AND;
    endproperty
    a_and_reg: assert property (p_and_reg)
        else $error("register AND misdecoded");

    // One assertion per remaining form, so a slip in one branch shows alone
    property p_adc_imm;
        @(posedge i_clk) disable iff (i_reset)
        i_op_valid && i_opcode == 8'h34 |=> o_dec.op == AOD_OP_ADC &&
            o_dec.src == AOD_SRC_IMM;
    endproperty
    a_adc_imm: assert property (p_adc_imm)
        else $error("immediate add with carry misdecoded");

    property p_sbb_dir;
        @(posedge i_clk) disable iff (i_reset)
        i_op_valid && i_opcode == 8'h95 |=> o_dec.op == AOD_OP_SBB &&
            o_dec.src == AOD_SRC_DIR && o_dec.bytes == 2'h2;
    endproperty
    a_sbb_dir: assert property (p_sbb_dir)
        else $error("direct subtract misdecoded");

    property p_sbb_imm;
        @(posedge i_clk) disable iff (i_reset)
        i_op_valid && i_opcode == 8'h94 |=> o_dec.op == AOD_OP_SBB &&
            o_dec.src == AOD_SRC_IMM && o_dec.cycles == 2'h2;
    endproperty
    a_sbb_imm: assert property (p_sbb_imm)
        else $error("immediate subtract misdecoded");

    property p_inc_acc;
        @(posedge i_clk) disable iff (i_reset)
        i_op_valid && i_opcode == 8'h04 |=> o_dec.op == AOD_OP_INC &&
            o_dec.src == AOD_SRC_ACC && o_dec.cycles == 2'h1;
    endproperty
    a_inc_acc: assert property (p_inc_acc)
        else $error("accumulator increment misdecoded");

    property p_inc_dir;
        @(posedge i_clk) disable iff (i_reset)
        i_op_valid && i_opcode == 8'h05 |=> o_dec.op == AOD_OP_INC &&
            o_dec.src == AOD_SRC_DIR && o_dec.bytes == 2'h2;
    endproperty
    a_inc_dir: assert property (p_inc_dir)
        else $error("direct increment misdecoded");

    property p_inc_ind;
        @(posedge i_clk) disable iff (i_reset)
        i_op_valid && i_opcode[7:1] == 7'h03 |=> o_dec.op == AOD_OP_INC &&
            o_dec.src == AOD_SRC_IND && o_dec.bytes == 2'h1;
    endproperty
    a_inc_ind: assert property (p_inc_ind)
        else $error("indirect increment misdecoded");

    property p_dec_acc;
        @(posedge i_clk) disable iff (i_reset)
        i_op_valid && i_opcode == 8'h14 |=> o_dec.op == AOD_OP_DEC &&
            o_dec.src == AOD_SRC_ACC && o_dec.cycles == 2'h1;
    endproperty
    a_dec_acc: assert property (p_dec_acc)
        else $error("accumulator decrement misdecoded");

    property p_dec_reg;
        @(posedge i_clk) disable iff (i_reset)
        i_op_valid && i_opcode[7:3] == 5'h03 |=> o_dec.op == AOD_OP_DEC &&
            o_dec.src == AOD_SRC_REG && o_dec.bytes == 2'h1;
    endproperty
    a_dec_reg: assert property (p_dec_reg)
        else $error("register decrement misdecoded");

    property p_dec_dir;
        @(posedge i_clk) disable iff (i_reset)
        i_op_valid && i_opcode == 8'h15 |=> o_dec.op == AOD_OP_DEC &&
            o_dec.src == AOD_SRC_DIR && o_dec.cycles == 2'h2;
    endproperty
    a_dec_dir: assert property (p_dec_dir)
        else $error("direct decrement misdecoded");

    // Plain add group sits next door and must stay out
    property p_refuse;
        @(posedge i_clk) disable iff (i_reset)
        i_op_valid && i_opcode[7:2] == 6'h09 |=> o_dec == DEC_RESET;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("foreign opcode decoded as own");

    property p_len_sane;
        @(posedge i_clk) disable iff (i_reset)
        o_dec.valid |-> o_dec.bytes != 2'h0 && o_dec.cycles != 2'h0;
    endproperty
    a_len_sane: assert property (p_len_sane)
        else $error("valid decode with zero length");

    property p_reset;
        @(posedge i_clk)
        i_reset |=> o_dec == DEC_RESET;
    endproperty
    a_reset: assert property (p_reset)
        else $error("decode not cleared by reset");

    property p_bank;
        @(posedge i_clk) disable iff (i_reset)
        o_dec.valid && o_dec.src == AOD_SRC_REG |->
            o_dec.bank_sel == $past(i_opcode[2:0]);
    endproperty
    a_bank: assert property (p_bank)
        else $error("bank select does not follow opcode");

    property p_ptr;
        @(posedge i_clk) disable iff (i_reset)
        o_dec.valid && o_dec.src == AOD_SRC_IND |->
            o_dec.ptr_sel == $past(i_opcode[0]);
    endproperty
    a_ptr: assert property (p_ptr)
        else $error("pointer select does not follow opcode");

    property p_carry;
        @(posedge i_clk) disable iff (i_reset)
        o_dec.valid |-> o_dec.use_carry == (o_dec.op == AOD_OP_ADC ||
            o_dec.op == AOD_OP_SBB) && o_dec.carry_upd == o_dec.use_carry;
    endproperty
    a_carry: assert property (p_carry)
        else $error("carry use does not match operation");

    property p_idle;
        @(posedge i_clk) disable iff (i_reset)
        !i_op_valid |=> !o_dec.valid && o_dec.cycles == 2'h0;
    endproperty
    a_idle: assert property (p_idle)
        else $error("output valid without input");

    c_adc: cover property (@(posedge i_clk) disable iff (i_reset)
        o_dec.valid && o_dec.op == AOD_OP_ADC);
    c_dpp: cover property (@(posedge i_clk) disable iff (i_reset)
        o_dec.valid && o_dec.src == AOD_SRC_DPP);
    c_b2b: cover property (@(posedge i_clk) disable iff (i_reset)
        o_dec.valid ##1 o_dec.valid);
    c_miss: cover property (@(posedge i_clk) disable iff (i_reset)
        in_q && !o_dec.valid && opc_q == 8'h24);
    c_two: cover property (@(posedge i_clk) disable iff (i_reset)
        o_dec.valid && o_dec.bytes == 2'h2);

endmodule : aod_arith_opcode_decode

`default_nettype wire

// *** aod_fetch_model.sv ***
`timescale 1ns/10ps
`default_nettype none

// Stands in for the fetch unit: one opcode byte per call, back to back
module aod_fetch_model (
    input  wire logic       i_clk,
    output var  logic       o_op_valid,
    output var  logic [7:0] o_opcode
);
    initial begin
        o_op_valid = 1'b0;
        o_opcode   = 8'h00;
    end

    task automatic send(input logic [7:0] op);
        o_op_valid <= 1'b1;
        o_opcode   <= op;
        @(posedge i_clk);
    endtask : send

    // Byte is stale when idle, so show its inverse rather than hold it
    task automatic idle();
        o_op_valid <= 1'b0;
        o_opcode   <= ~o_opcode;
        @(posedge i_clk);
    endtask : idle
endmodule : aod_fetch_model

`default_nettype wire

// *** aod_arith_opcode_decode_tb.sv ***
`timescale 1ns/10ps
`default_nettype none

module aod_arith_opcode_decode_tb;
    import aod_pkg::*;

    logic     i_clk;
    logic     i_reset;
    logic     op_valid;
    logic [7:0] opcode;
    aod_dec_t o_dec;
    aod_dec_t exp_q;
    logic     chk_en;
    int       err_total;
    int       total_checks;

    aod_fetch_model fetch_u (
        .i_clk      (i_clk),
        .o_op_valid (op_valid),
        .o_opcode   (opcode)
    );

    aod_arith_opcode_decode dut_u (
        .i_clk      (i_clk),
        .i_reset    (i_reset),
        .i_op_valid (op_valid),
        .i_opcode   (opcode),
        .o_dec      (o_dec)
    );

    function automatic aod_dec_t mk(input logic [7:0] op, input aod_op_t k,
                                    input aod_src_t s, input logic [1:0] b,
                                    input logic [1:0] c);
        aod_dec_t d;
        d           = DEC_RESET;
        d.valid     = 1'b1;
        d.op        = k;
        d.src       = s;
        d.bank_sel  = op[2:0];
        d.ptr_sel   = op[0];
        d.use_carry = (k == AOD_OP_ADC) || (k == AOD_OP_SBB);
        d.carry_upd = d.use_carry;
        d.bytes     = b;
        d.cycles    = c;
        return d;
    endfunction : mk

    function automatic aod_dec_t exp_dec(input logic [7:0] op);
        casez (op)
            8'h36, 8'h37: return mk(op, AOD_OP_ADC, AOD_SRC_IND, 2'h1, 2'h1);
            8'h34:        return mk(op, AOD_OP_ADC, AOD_SRC_IMM, 2'h2, 2'h2);
            8'b1001_1???: return mk(op, AOD_OP_SBB, AOD_SRC_REG, 2'h1, 2'h1);
            8'h95:        return mk(op, AOD_OP_SBB, AOD_SRC_DIR, 2'h2, 2'h2);
            8'h96, 8'h97: return mk(op, AOD_OP_SBB, AOD_SRC_IND, 2'h1, 2'h1);
            8'h94:        return mk(op, AOD_OP_SBB, AOD_SRC_IMM, 2'h2, 2'h2);
            8'h04:        return mk(op, AOD_OP_INC, AOD_SRC_ACC, 2'h1, 2'h1);
            8'b0000_1???: return mk(op, AOD_OP_INC, AOD_SRC_REG, 2'h1, 2'h1);
            8'h05:        return mk(op, AOD_OP_INC, AOD_SRC_DIR, 2'h2, 2'h2);
            8'h06, 8'h07: return mk(op, AOD_OP_INC, AOD_SRC_IND, 2'h1, 2'h1);
            8'h14:        return mk(op, AOD_OP_DEC, AOD_SRC_ACC, 2'h1, 2'h1);
            8'b0001_1???: return mk(op, AOD_OP_DEC, AOD_SRC_REG, 2'h1, 2'h1);
            8'h15:        return mk(op, AOD_OP_DEC, AOD_SRC_DIR, 2'h2, 2'h2);
            8'h16, 8'h17: return mk(op, AOD_OP_DEC, AOD_SRC_IND, 2'h1, 2'h1);
            8'hA3:        return mk(op, AOD_OP_INC, AOD_SRC_DPP, 2'h1, 2'h3);
            8'b0101_1???: return mk(op, AOD_OP_AND, AOD_SRC_REG, 2'h1, 2'h1);
            default:      return DEC_RESET;
        endcase
    endfunction : exp_dec

    task automatic check_dec(input aod_dec_t exp, input aod_dec_t got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value o_dec exp %h got %h", exp, got);
        end
    endtask : check_dec

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    task automatic sweep(input int lo, input int hi);
        for (int i = lo; i <= hi; i++) begin
            fetch_u.send(8'(i));
        end
        $display("test sweep %h..%h done", lo, hi);
    endtask : sweep

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // Result is one edge behind the opcode, so model it from that edge
    always @(posedge i_clk) begin
        exp_q = (i_reset || !op_valid) ? DEC_RESET : exp_dec(opcode);
        #1;
        if (chk_en) begin
            check_dec(exp_q, o_dec);
        end
    end

    initial begin
        repeat (3000) @(posedge i_clk);
        err_total++;
        final_report();
    end

    initial begin
        i_reset      = 1'b1;
        chk_en       = 1'b0;
        err_total    = 0;
        total_checks = 0;
        void'($urandom(91));
        repeat (10) @(posedge i_clk);
        chk_en  <= 1'b1;
        i_reset <= 1'b0;
        sweep(8'h00, 8'h0F);
        sweep(8'h10, 8'h1F);
        sweep(8'h20, 8'h7F);
        sweep(8'h80, 8'hFF);
        for (int i = 0; i < 400; i++) begin
            if ($urandom % 4 == 0) begin
                fetch_u.idle();
            end else begin
                fetch_u.send(8'($urandom));
            end
        end
        $display("test random done");
        // Reset mid-stream drops opcodes taken under it
        i_reset <= 1'b1;
        fetch_u.send(8'h98);
        fetch_u.send(8'hA3);
        i_reset <= 1'b0;
        fetch_u.send(8'h9F);
        fetch_u.send(8'hA3);
        fetch_u.idle();
        fetch_u.idle();
        $display("test reset done");
        final_report();
    end
endmodule : aod_arith_opcode_decode_tb

`default_nettype wire
